// [rtl/mod_pkg.sv]
// package for the opcode decoder: opcode patterns, operation classes,
// addressing modes and cycle counts.
// assumes an 8-bit core with a 16-bit code address space.
package mod_pkg;
    localparam logic [7:0] OP_ADD_IMM = 8'h24;
    localparam logic [7:0] OP_ADD_DIR = 8'h25;
    localparam logic [7:0] OP_ADWC_IMM = 8'h34;
    localparam logic [7:0] OP_ADWC_DIR = 8'h35;
    localparam logic [7:0] OP_SBWB_IMM = 8'h94;
    localparam logic [7:0] OP_SBWB_DIR = 8'h95;
    localparam logic [7:0] OP_OR_DA = 8'h42;
    localparam logic [7:0] OP_OR_DI = 8'h43;
    localparam logic [7:0] OP_OR_IMM = 8'h44;
    localparam logic [7:0] OP_OR_DIR = 8'h45;
    localparam logic [7:0] OP_AND_DA = 8'h52;
    localparam logic [7:0] OP_AND_DI = 8'h53;
    localparam logic [7:0] OP_AND_IMM = 8'h54;
    localparam logic [7:0] OP_AND_DIR = 8'h55;
    localparam logic [7:0] OP_XOR_DA = 8'h62;
    localparam logic [7:0] OP_XOR_DI = 8'h63;
    localparam logic [7:0] OP_XOR_IMM = 8'h64;
    localparam logic [7:0] OP_XOR_DIR = 8'h65;
    localparam logic [7:0] OP_ROR = 8'h03;
    localparam logic [7:0] OP_RORC = 8'h13;
    localparam logic [7:0] OP_ROL = 8'h23;
    localparam logic [7:0] OP_ROLC = 8'h33;
    localparam logic [7:0] OP_SWAP = 8'hC4;
    localparam logic [7:0] OP_CLRA = 8'hE4;
    localparam logic [7:0] OP_CPLA = 8'hF4;
    localparam logic [7:0] OP_LDA_DIR = 8'hE5;
    localparam logic [7:0] OP_LDA_IMM = 8'h74;
    localparam logic [7:0] OP_STD_ACC = 8'hF5;
    localparam logic [7:0] OP_STD_DIR = 8'h85;
    localparam logic [7:0] OP_STD_IMM = 8'h75;
    localparam logic [7:0] OP_LD_DP = 8'h90;
    localparam logic [7:0] OP_CODE_DP = 8'h93;
    localparam logic [7:0] OP_CODE_PC = 8'h83;
    localparam logic [7:0] OP_XRD_DP = 8'hE0;
    localparam logic [7:0] OP_XWR_DP = 8'hF0;
    localparam logic [7:0] OP_PUSH = 8'hC0;
    localparam logic [7:0] OP_POP = 8'hD0;
    localparam logic [7:0] OP_XCG_DIR = 8'hC5;
    // high five bits of register forms (low three pick the register)
    localparam logic [4:0] HI_ADD_R = 5'h05;
    localparam logic [4:0] HI_ADWC_R = 5'h07;
    localparam logic [4:0] HI_SBWB_R = 5'h13;
    localparam logic [4:0] HI_OR_R = 5'h09;
    localparam logic [4:0] HI_AND_R = 5'h0B;
    localparam logic [4:0] HI_XOR_R = 5'h0D;
    localparam logic [4:0] HI_LDA_R = 5'h1D;
    localparam logic [4:0] HI_RA = 5'h1F;
    localparam logic [4:0] HI_RDIR = 5'h15;
    localparam logic [4:0] HI_RIMM = 5'h0F;
    localparam logic [4:0] HI_DR = 5'h11;
    localparam logic [4:0] HI_XCG_R = 5'h19;
    // high seven bits of indirect forms (low bit picks R0/R1)
    localparam logic [6:0] HI_ADD_I = 7'h13;
    localparam logic [6:0] HI_ADWC_I = 7'h1B;
    localparam logic [6:0] HI_SBWB_I = 7'h4B;
    localparam logic [6:0] HI_OR_I = 7'h23;
    localparam logic [6:0] HI_AND_I = 7'h2B;
    localparam logic [6:0] HI_XOR_I = 7'h33;
    localparam logic [6:0] HI_LDA_I = 7'h73;
    localparam logic [6:0] HI_DI = 7'h43;
    localparam logic [6:0] HI_IA = 7'h7B;
    localparam logic [6:0] HI_IDIR = 7'h53;
    localparam logic [6:0] HI_IIMM = 7'h3B;
    localparam logic [6:0] HI_XRD_I = 7'h71;
    localparam logic [6:0] HI_XWR_I = 7'h79;
    localparam logic [6:0] HI_XCG_I = 7'h63;
    localparam logic [6:0] HI_XCGN_I = 7'h6B;

    localparam logic [7:0] SPA_BASE = 8'h80;
    localparam int BANK_W = 2;
    localparam int REG_SEL_W = 3;
    localparam int PAGE_BITS = 11;
    localparam logic [3:0] XRD_MAX_CYC = 4'hA;
    localparam logic [3:0] XWR_MAX_CYC = 4'hB;
    localparam int CARRY_BIT = 7;
    localparam int BSEL_HI = 4;
    localparam int BSEL_LO = 3;
    localparam logic [7:0] STATUS_RESET = 8'h00;

    typedef enum logic [4:0] {
        OPC_OTHER = 5'b00000, OPC_ADD = 5'b00001, OPC_ADWC = 5'b00010,
        OPC_SBWB = 5'b00011, OPC_AND = 5'b00100, OPC_OR = 5'b00101,
        OPC_XOR = 5'b00110, OPC_ROL = 5'b00111, OPC_ROLC = 5'b01000,
        OPC_ROR = 5'b01001, OPC_RORC = 5'b01010, OPC_SWAP = 5'b01011,
        OPC_CLR = 5'b01100, OPC_CPL = 5'b01101, OPC_CPY = 5'b01110,
        OPC_LDDP = 5'b01111, OPC_CODE = 5'b10000, OPC_XRD = 5'b10001,
        OPC_XWR = 5'b10010, OPC_PUSH = 5'b10011, OPC_POP = 5'b10100,
        OPC_XCG = 5'b10101, OPC_XCGN = 5'b10110
    } mod_opclass_t;

    // source/destination operand mode
    typedef enum logic [3:0] {
        AM_NONE = 4'b0000, AM_ACC = 4'b0001, AM_REG = 4'b0010,
        AM_DIR = 4'b0011, AM_IND = 4'b0100, AM_IMM = 4'b0101,
        AM_IMM16 = 4'b0110, AM_ACCDP = 4'b0111, AM_ACCPC = 4'b1000,
        AM_XDP = 4'b1001, AM_XIND = 4'b1010, AM_STACK = 4'b1011
    } mod_amode_t;
endpackage : mod_pkg

// [rtl/mod_reg_bank_file.sv]
// register-bank store: four banks of eight bytes, registered read port.
// assumes writes and reads come from the execution datapath.
`timescale 1ns/1ps
`default_nettype none
module mod_reg_bank_file import mod_pkg::*; #(
    parameter int BANKS = 4,
    parameter int REGS = 8
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [BANK_W-1:0] bankSel,
    input wire logic [REG_SEL_W-1:0] rdSel,
    input wire logic wrEn,
    input wire logic [REG_SEL_W-1:0] wrSel,
    input wire logic [7:0] wrData,
    output logic [7:0] rdData
);
    logic [7:0] mem [BANKS*REGS];
    logic [7:0] rdData_ff;

    always_ff @(posedge ref_clk) begin
        if (wrEn) begin
            mem[{bankSel, wrSel}] <= wrData;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rdData_ff <= 8'h00;
        end else begin
            rdData_ff <= mem[{bankSel, rdSel}];
        end
    end

    assign rdData = rdData_ff;
endmodule : mod_reg_bank_file
`default_nettype wire

// [rtl/mod_opcode_decoder.sv]
// opcode decoder for the 8-bit core: class, modes, length, cycles,
// operand address forming, branch target forming and status word.
// assumes the fetch path presents a valid first byte with opValid.
`timescale 1ns/1ps
`default_nettype none
module mod_opcode_decoder import mod_pkg::*; #(
    parameter int ADDR_W = 16
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic opValid,
    input wire logic [7:0] opcode,
    input wire logic [7:0] operandByte,
    input wire logic [7:0] operandByte2,
    input wire logic [ADDR_W-1:0] nextPc,
    input wire logic arithDone,
    input wire logic arithCarry,
    input wire logic statusWrEn,
    input wire logic [7:0] statusWrMask,
    input wire logic [7:0] statusWrData,
    input wire logic regWrEn,
    input wire logic [REG_SEL_W-1:0] regWrSel,
    input wire logic [7:0] regWrData,
    output logic [4:0] opClass,
    output logic [3:0] srcMode,
    output logic [3:0] dstMode,
    output logic [1:0] instLen,
    output logic [3:0] cycMin,
    output logic [3:0] cycMax,
    output logic otherDecode,
    output logic [REG_SEL_W-1:0] bankRegSel,
    output logic [7:0] bankRegAddr,
    output logic directIsSfr,
    output logic [7:0] directAddr,
    output logic [7:0] indexRegData,
    output logic [ADDR_W-1:0] longTarget,
    output logic [ADDR_W-1:0] pageTarget,
    output logic [ADDR_W-1:0] relTarget,
    output logic [7:0] statusWord,
    output logic carryFlag
);
    typedef struct packed {
        logic [7:0] status;
    } mod_state_t;

    typedef struct packed {
        mod_opclass_t cls;
        mod_amode_t src;
        mod_amode_t dst;
        logic [1:0] len;
        logic [3:0] cmin;
        logic [3:0] cmax;
    } mod_dec_t;

    mod_state_t cur_ff;
    mod_state_t nxt_cur;
    mod_dec_t dec;
    logic [BANK_W-1:0] bankSel;

    function automatic mod_dec_t mk(mod_opclass_t c, mod_amode_t s, mod_amode_t d,
                                    logic [1:0] l, logic [3:0] n);
        mk = '{cls: c, src: s, dst: d, len: l, cmin: n, cmax: n};
    endfunction : mk

    // arithmetic/logic accumulator group: register, direct, indirect, immediate
    function automatic mod_dec_t aluForm(mod_opclass_t c, logic [7:0] op);
        unique case (op[3:0]) inside
            [4'h8:4'hF]: aluForm = mk(c, AM_REG, AM_ACC, 2'd1, 4'd1);
            4'h5: aluForm = mk(c, AM_DIR, AM_ACC, 2'd2, 4'd2);
            4'h6, 4'h7: aluForm = mk(c, AM_IND, AM_ACC, 2'd1, 4'd2);
            default: aluForm = mk(c, AM_IMM, AM_ACC, 2'd2, 4'd2);
        endcase
    endfunction : aluForm

    always_comb begin
        dec = mk(OPC_OTHER, AM_NONE, AM_NONE, 2'd1, 4'd1);
        if (opcode[7:3] == HI_ADD_R || opcode[7:1] == HI_ADD_I
            || opcode == OP_ADD_DIR || opcode == OP_ADD_IMM) begin
            dec = aluForm(OPC_ADD, opcode);
        end else if (opcode[7:3] == HI_ADWC_R || opcode[7:1] == HI_ADWC_I
            || opcode == OP_ADWC_DIR || opcode == OP_ADWC_IMM) begin
            dec = aluForm(OPC_ADWC, opcode);
        end else if (opcode[7:3] == HI_SBWB_R || opcode[7:1] == HI_SBWB_I
            || opcode == OP_SBWB_DIR || opcode == OP_SBWB_IMM) begin
            dec = aluForm(OPC_SBWB, opcode);
        end else if (opcode[7:3] == HI_AND_R || opcode[7:1] == HI_AND_I
            || opcode == OP_AND_DIR || opcode == OP_AND_IMM) begin
            dec = aluForm(OPC_AND, opcode);
        end else if (opcode == OP_AND_DA) begin
            dec = mk(OPC_AND, AM_ACC, AM_DIR, 2'd2, 4'd3);
        end else if (opcode == OP_AND_DI) begin
            dec = mk(OPC_AND, AM_IMM, AM_DIR, 2'd3, 4'd4);
        end else if (opcode[7:3] == HI_OR_R || opcode[7:1] == HI_OR_I
            || opcode == OP_OR_DIR || opcode == OP_OR_IMM) begin
            dec = aluForm(OPC_OR, opcode);
        end else if (opcode == OP_OR_DA) begin
            dec = mk(OPC_OR, AM_ACC, AM_DIR, 2'd2, 4'd3);
        end else if (opcode == OP_OR_DI) begin
            dec = mk(OPC_OR, AM_IMM, AM_DIR, 2'd3, 4'd4);
        end else if (opcode[7:3] == HI_XOR_R || opcode[7:1] == HI_XOR_I
            || opcode == OP_XOR_DIR || opcode == OP_XOR_IMM) begin
            dec = aluForm(OPC_XOR, opcode);
        end else if (opcode == OP_XOR_DA) begin
            dec = mk(OPC_XOR, AM_ACC, AM_DIR, 2'd2, 4'd3);
        end else if (opcode == OP_XOR_DI) begin
            dec = mk(OPC_XOR, AM_IMM, AM_DIR, 2'd3, 4'd4);
        end else if (opcode == OP_ROL) begin
            dec = mk(OPC_ROL, AM_ACC, AM_ACC, 2'd1, 4'd1);
        end else if (opcode == OP_ROLC) begin
            dec = mk(OPC_ROLC, AM_ACC, AM_ACC, 2'd1, 4'd1);
        end else if (opcode == OP_ROR) begin
            dec = mk(OPC_ROR, AM_ACC, AM_ACC, 2'd1, 4'd1);
        end else if (opcode == OP_RORC) begin
            dec = mk(OPC_RORC, AM_ACC, AM_ACC, 2'd1, 4'd1);
        end else if (opcode == OP_SWAP) begin
            dec = mk(OPC_SWAP, AM_ACC, AM_ACC, 2'd1, 4'd1);
        end else if (opcode == OP_CLRA) begin
            dec = mk(OPC_CLR, AM_NONE, AM_ACC, 2'd1, 4'd1);
        end else if (opcode == OP_CPLA) begin
            dec = mk(OPC_CPL, AM_ACC, AM_ACC, 2'd1, 4'd1);
        end else if (opcode[7:3] == HI_LDA_R || opcode[7:1] == HI_LDA_I
            || opcode == OP_LDA_DIR || opcode == OP_LDA_IMM) begin
            dec = aluForm(OPC_CPY, opcode);
        end else if (opcode[7:3] == HI_RA) begin
            dec = mk(OPC_CPY, AM_ACC, AM_REG, 2'd1, 4'd2);
        end else if (opcode[7:3] == HI_RDIR) begin
            dec = mk(OPC_CPY, AM_DIR, AM_REG, 2'd2, 4'd4);
        end else if (opcode[7:3] == HI_RIMM) begin
            dec = mk(OPC_CPY, AM_IMM, AM_REG, 2'd2, 4'd2);
        end else if (opcode == OP_STD_ACC) begin
            dec = mk(OPC_CPY, AM_ACC, AM_DIR, 2'd2, 4'd3);
        end else if (opcode[7:3] == HI_DR) begin
            dec = mk(OPC_CPY, AM_REG, AM_DIR, 2'd2, 4'd3);
        end else if (opcode == OP_STD_DIR) begin
            dec = mk(OPC_CPY, AM_DIR, AM_DIR, 2'd3, 4'd4);
        end else if (opcode[7:1] == HI_DI) begin
            dec = mk(OPC_CPY, AM_IND, AM_DIR, 2'd2, 4'd4);
        end else if (opcode == OP_STD_IMM) begin
            dec = mk(OPC_CPY, AM_IMM, AM_DIR, 2'd3, 4'd3);
        end else if (opcode[7:1] == HI_IA) begin
            dec = mk(OPC_CPY, AM_ACC, AM_IND, 2'd1, 4'd3);
        end else if (opcode[7:1] == HI_IDIR) begin
            dec = mk(OPC_CPY, AM_DIR, AM_IND, 2'd2, 4'd5);
        end else if (opcode[7:1] == HI_IIMM) begin
            dec = mk(OPC_CPY, AM_IMM, AM_IND, 2'd2, 4'd3);
        end else if (opcode == OP_LD_DP) begin
            dec = mk(OPC_LDDP, AM_IMM16, AM_NONE, 2'd3, 4'd3);
        end else if (opcode == OP_CODE_DP) begin
            dec = mk(OPC_CODE, AM_ACCDP, AM_ACC, 2'd1, 4'd3);
        end else if (opcode == OP_CODE_PC) begin
            dec = mk(OPC_CODE, AM_ACCPC, AM_ACC, 2'd1, 4'd3);
        end else if (opcode == OP_XRD_DP || opcode[7:1] == HI_XRD_I) begin
            // wait states set the real count; min and max bound it
            dec = mk(OPC_XRD, (opcode == OP_XRD_DP) ? AM_XDP : AM_XIND,
                     AM_ACC, 2'd1, 4'd3);
            dec.cmax = XRD_MAX_CYC;
        end else if (opcode == OP_XWR_DP || opcode[7:1] == HI_XWR_I) begin
            dec = mk(OPC_XWR, AM_ACC, (opcode == OP_XWR_DP) ? AM_XDP : AM_XIND,
                     2'd1, 4'd4);
            dec.cmax = XWR_MAX_CYC;
        end else if (opcode == OP_PUSH) begin
            dec = mk(OPC_PUSH, AM_DIR, AM_STACK, 2'd2, 4'd4);
        end else if (opcode == OP_POP) begin
            dec = mk(OPC_POP, AM_STACK, AM_DIR, 2'd2, 4'd3);
        end else if (opcode[7:3] == HI_XCG_R) begin
            dec = mk(OPC_XCG, AM_REG, AM_ACC, 2'd1, 4'd2);
        end else if (opcode == OP_XCG_DIR) begin
            dec = mk(OPC_XCG, AM_DIR, AM_ACC, 2'd2, 4'd3);
        end else if (opcode[7:1] == HI_XCG_I) begin
            dec = mk(OPC_XCG, AM_IND, AM_ACC, 2'd1, 4'd3);
        end else if (opcode[7:1] == HI_XCGN_I) begin
            dec = mk(OPC_XCGN, AM_IND, AM_ACC, 2'd1, 4'd3);
        end
    end

    // purely combinational so the sequencer sees it with the first byte
    assign opClass = dec.cls;
    assign srcMode = dec.src;
    assign dstMode = dec.dst;
    assign instLen = dec.len;
    assign cycMin = dec.cmin;
    assign cycMax = dec.cmax;
    assign otherDecode = opValid && (dec.cls == OPC_OTHER);

    assign bankSel = cur_ff.status[BSEL_HI:BSEL_LO];
    assign bankRegSel = opcode[REG_SEL_W-1:0];
    assign bankRegAddr = {3'h0, bankSel, opcode[REG_SEL_W-1:0]};
    assign directAddr = operandByte;
    assign directIsSfr = operandByte >= SPA_BASE;

    // index register content (R0/R1) from the bank store, one cycle later
    mod_reg_bank_file #(
        .BANKS(4),
        .REGS(8)
    ) u_bank (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .bankSel(bankSel),
        .rdSel({2'b00, opcode[0]}),
        .wrEn(regWrEn),
        .wrSel(regWrSel),
        .wrData(regWrData),
        .rdData(indexRegData)
    );

    assign longTarget = {operandByte, operandByte2};
    assign pageTarget = {nextPc[ADDR_W-1:PAGE_BITS],
                         opcode[7:5], operandByte};
    assign relTarget = nextPc + ADDR_W'(signed'(operandByte));

    always_comb begin
        nxt_cur = cur_ff;
        // explicit writes first; flag update from the ALU wins on its bit
        if (statusWrEn) begin
            nxt_cur.status = (cur_ff.status & ~statusWrMask)
                           | (statusWrData & statusWrMask);
        end
        if (arithDone) begin
            nxt_cur.status[CARRY_BIT] = arithCarry;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            cur_ff <= '{status: STATUS_RESET};
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    assign statusWord = cur_ff.status;
    assign carryFlag = cur_ff.status[CARRY_BIT];
endmodule : mod_opcode_decoder
`default_nettype wire

// [test/mod_decoder_monitor.sv]
// checker for the opcode decoder: operand forming, status word, decode sanity.
// assumes it is bound to the decoder top and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module mod_decoder_monitor import mod_pkg::*; #(
    parameter int ADDR_W = 16
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic opValid,
    input wire logic [7:0] opcode,
    input wire logic [7:0] operandByte,
    input wire logic [7:0] operandByte2,
    input wire logic [ADDR_W-1:0] nextPc,
    input wire logic arithDone,
    input wire logic arithCarry,
    input wire logic statusWrEn,
    input wire logic [7:0] statusWrMask,
    input wire logic [7:0] statusWrData,
    input wire logic [4:0] opClass,
    input wire logic [1:0] instLen,
    input wire logic [3:0] cycMin,
    input wire logic [3:0] cycMax,
    input wire logic otherDecode,
    input wire logic [7:0] bankRegAddr,
    input wire logic directIsSfr,
    input wire logic [ADDR_W-1:0] longTarget,
    input wire logic [ADDR_W-1:0] pageTarget,
    input wire logic [ADDR_W-1:0] relTarget,
    input wire logic [7:0] statusWord,
    input wire logic carryFlag
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    chk_bank_addr: assert property (bankRegAddr == {3'h0, statusWord[BSEL_HI:BSEL_LO], opcode[2:0]})
        else $error("bank register address does not follow bank field and opcode");
    chk_direct_area: assert property (directIsSfr == (operandByte >= SPA_BASE))
        else $error("direct area decision wrong");
    chk_long_pair: assert property (longTarget == {operandByte, operandByte2})
        else $error("long target not formed from both operand bytes");
    chk_page_keep: assert property (pageTarget == {nextPc[ADDR_W-1:PAGE_BITS], opcode[7:5], operandByte})
        else $error("page target left its page");
    chk_rel_sum: assert property (relTarget == nextPc + {{(ADDR_W-8){operandByte[7]}}, operandByte})
        else $error("relative target sum wrong");
    chk_status_write: assert property (statusWrEn && !arithDone |=> statusWord == ($past(statusWord) & ~$past(statusWrMask) | $past(statusWrData) & $past(statusWrMask)))
        else $error("status word write not applied");
    chk_status_hold: assert property (!statusWrEn && !arithDone |=> $stable(statusWord) && carryFlag == statusWord[CARRY_BIT])
        else $error("status word changed without cause");
    chk_carry_set: assert property (arithDone |=> carryFlag == $past(arithCarry))
        else $error("carry flag does not follow arithmetic result");
    chk_other_flag: assert property (otherDecode |-> opValid && opClass == OPC_OTHER && instLen == 2'h1 && cycMin == 4'h1)
        else $error("foreign opcode flagged with wrong decode");
    chk_ext_cycles: assert property (opClass == OPC_XWR |-> cycMin == 4'h4 && cycMax == XWR_MAX_CYC)
        else $error("external write cycle range wrong");

    cov_other: cover property (otherDecode);
    cov_carry: cover property (arithDone && arithCarry);
    cov_bank3: cover property (statusWrEn ##1 statusWord[BSEL_HI:BSEL_LO] == 2'h3);
endmodule : mod_decoder_monitor

bind mod_opcode_decoder mod_decoder_monitor #(.ADDR_W(ADDR_W)) u_mod_decoder_monitor (.*);
`default_nettype wire

// [test/mod_fetch_model.sv]
// fetch path and sequencer stand-in: presents instruction bytes and write pulses.
// assumes the bench calls its tasks; everything changes 1 ns after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module mod_fetch_model (
    input wire logic ref_clk,
    output logic opValid,
    output logic [7:0] opcode,
    output logic [7:0] operandByte,
    output logic [7:0] operandByte2,
    output logic [15:0] nextPc,
    output logic arithDone,
    output logic arithCarry,
    output logic statusWrEn,
    output logic [7:0] statusWrMask,
    output logic [7:0] statusWrData,
    output logic regWrEn,
    output logic [2:0] regWrSel,
    output logic [7:0] regWrData
);
    initial begin
        {opValid, opcode, operandByte, operandByte2, nextPc, arithDone, arithCarry,
            statusWrEn, statusWrMask, statusWrData, regWrEn, regWrSel, regWrData} = '0;
    end

    task automatic issue(input logic v, input logic [7:0] op, input logic [7:0] b1,
        input logic [7:0] b2, input logic [15:0] pc);
        @(posedge ref_clk);
        #1;
        {opValid, opcode, operandByte, operandByte2, nextPc} = {v, op, b1, b2, pc};
    endtask : issue

    // one-cycle write pulse; enables drop to 0 afterwards and data fields are inverted so stale values never match
    task automatic pulse(input logic ad, input logic ac, input logic se, input logic [7:0] m,
        input logic [7:0] d, input logic re, input logic [2:0] rs, input logic [7:0] rd);
        @(posedge ref_clk);
        #1;
        {arithDone, arithCarry, statusWrEn, statusWrMask, statusWrData} = {ad, ac, se, m, d};
        {regWrEn, regWrSel, regWrData} = {re, rs, rd};
        @(posedge ref_clk);
        #1;
        {arithDone, arithCarry, statusWrEn, statusWrMask, statusWrData} = {1'b0, ~ac, 1'b0, ~m, ~d};
        {regWrEn, regWrSel, regWrData} = {1'b0, ~rs, ~rd};
    endtask : pulse
endmodule : mod_fetch_model
`default_nettype wire

// [test/testbench.sv]
// self-checking bench for the opcode decoder with the fetch model as driver.
// assumes a 200 MHz core clock and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module testbench import mod_pkg::*;;
    logic ref_clk;
    logic rst_n;
    logic opValid, arithDone, arithCarry, statusWrEn, regWrEn, otherDecode, directIsSfr, carryFlag;
    logic [7:0] opcode, operandByte, operandByte2, statusWrMask, statusWrData, regWrData;
    logic [7:0] bankRegAddr, directAddr, indexRegData, statusWord;
    logic [2:0] regWrSel, bankRegSel;
    logic [15:0] nextPc, longTarget, pageTarget, relTarget;
    logic [4:0] opClass;
    logic [3:0] srcMode, dstMode, cycMin, cycMax;
    logic [1:0] instLen;
    int err_total = 0;
    int comparisons = 0;
    // opcode, class, length, cycles
    logic [23:0] decTab [$] = '{24'h280111, 24'h2F0111, 24'h250122, 24'h260112, 24'h270112,
        24'h240122, 24'h380211, 24'h3F0211, 24'h350222, 24'h370212, 24'h340222, 24'h980311,
        24'h9F0311, 24'h950322, 24'h970312, 24'h940322, 24'h580411, 24'h5F0411, 24'h550422,
        24'h570412, 24'h540422, 24'h520423, 24'h530434, 24'h480511, 24'h4F0511, 24'h450522,
        24'h470512, 24'h440522, 24'h420523, 24'h430534, 24'h680611, 24'h6F0611, 24'h650622,
        24'h670612, 24'h640622, 24'h620623, 24'h630634, 24'h230711, 24'h330811, 24'h030911,
        24'h130A11, 24'hC40B11, 24'hE40C11, 24'hF40D11, 24'hE80E11, 24'hEF0E11, 24'hE50E22,
        24'hE70E12, 24'h740E22, 24'hF80E12, 24'hFF0E12, 24'hA80E24, 24'hAF0E24, 24'h780E22,
        24'h7F0E22, 24'hF50E23, 24'h880E23, 24'h8F0E23, 24'h850E34, 24'h870E24, 24'h750E33,
        24'hF60E13, 24'hF70E13, 24'hA60E25, 24'hA70E25, 24'h760E23, 24'h770E23, 24'h900F33,
        24'h931013, 24'h831013, 24'hE01113, 24'hE31113, 24'hF01214, 24'hF21214, 24'hC01324,
        24'hD01423, 24'hC81512, 24'hCF1512, 24'hC51523, 24'hC71513, 24'hD61613, 24'hD71613,
        24'h000011, 24'h800011, 24'h040011, 24'hA40011, 24'h120011, 24'hE10011, 24'hD40011};

    mod_fetch_model u_mod_fetch_model (.*);

    mod_opcode_decoder #(.ADDR_W(16)) u_mod_opcode_decoder (.*);

    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic close_out();
        if (err_total == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : close_out

    task automatic fetch(input logic [7:0] op, input logic [7:0] b1, input logic [15:0] pc);
        u_mod_fetch_model.issue(1'b1, op, b1, 8'hC3, pc);
        #1;
    endtask : fetch

    task automatic run_bank();
        check("statusWord reset", 16'(statusWord), 16'(STATUS_RESET));
        for (int b = 0; b < 4; b++) begin
            u_mod_fetch_model.pulse(1'b0, 1'b0, 1'b1, 8'h18, 8'(b << 3), 1'b0, 3'h0, 8'h00);
            fetch(8'h2D, 8'h00, 16'h0000);
            check("bankRegAddr", 16'(bankRegAddr), 16'(b * 8 + 5));
            check("bankRegSel", 16'(bankRegSel), 16'h0005);
        end
        u_mod_fetch_model.pulse(1'b0, 1'b0, 1'b1, 8'h80, 8'hFF, 1'b0, 3'h0, 8'h00);
        check("carry by write", 16'({carryFlag, statusWord}), 16'h0198);
        u_mod_fetch_model.pulse(1'b1, 1'b0, 1'b0, 8'h00, 8'h00, 1'b0, 3'h0, 8'h00);
        check("carry cleared", 16'({carryFlag, statusWord}), 16'h0018);
        u_mod_fetch_model.pulse(1'b1, 1'b1, 1'b0, 8'h00, 8'h00, 1'b0, 3'h0, 8'h00);
        check("carry set", 16'({carryFlag, statusWord}), 16'h0198);
        // arithmetic result owns the carry when both land together
        u_mod_fetch_model.pulse(1'b1, 1'b0, 1'b1, 8'h9F, 8'h80, 1'b0, 3'h0, 8'h00);
        check("carry vs write", 16'({carryFlag, statusWord}), 16'h0000);
    endtask : run_bank

    task automatic idx_check(input logic [7:0] bank, input logic [7:0] op, input logic [7:0] exp);
        u_mod_fetch_model.pulse(1'b0, 1'b0, 1'b1, 8'h18, bank, 1'b0, 3'h0, 8'h00);
        fetch(op, 8'h00, 16'h0000);
        @(posedge ref_clk);
        #1;
        check("indexRegData", 16'(indexRegData), 16'(exp));
    endtask : idx_check

    task automatic run_index();
        u_mod_fetch_model.pulse(1'b0, 1'b0, 1'b1, 8'h18, 8'h10, 1'b0, 3'h0, 8'h00);
        u_mod_fetch_model.pulse(1'b0, 1'b0, 1'b0, 8'h00, 8'h00, 1'b1, 3'h0, 8'h5A);
        u_mod_fetch_model.pulse(1'b0, 1'b0, 1'b0, 8'h00, 8'h00, 1'b1, 3'h1, 8'hA5);
        u_mod_fetch_model.pulse(1'b0, 1'b0, 1'b1, 8'h18, 8'h18, 1'b0, 3'h0, 8'h00);
        u_mod_fetch_model.pulse(1'b0, 1'b0, 1'b0, 8'h00, 8'h00, 1'b1, 3'h1, 8'h3C);
        idx_check(8'h18, 8'h27, 8'h3C);
        idx_check(8'h10, 8'h27, 8'hA5);
        idx_check(8'h10, 8'h26, 8'h5A);
    endtask : run_index

    task automatic run_table();
        logic [7:0] cls;
        foreach (decTab[i]) begin
            fetch(decTab[i][23:16], 8'h00, 16'h0000);
            cls = decTab[i][15:8];
            check("opClass", 16'(opClass), 16'(cls));
            check("instLen", 16'(instLen), 16'(decTab[i][7:4]));
            check("cycMin", 16'(cycMin), 16'(decTab[i][3:0]));
            check("cycMax", 16'(cycMax), 16'((cls == 8'h11) ? XRD_MAX_CYC : (cls == 8'h12) ?
                XWR_MAX_CYC : decTab[i][3:0]));
            check("otherDecode", 16'(otherDecode), 16'(cls == 8'h00));
        end
        fetch(8'h25, 8'h00, 16'h0000);
        check("srcMode", 16'(srcMode), 16'(AM_DIR));
        check("dstMode", 16'(dstMode), 16'(AM_ACC));
        u_mod_fetch_model.issue(1'b0, 8'hA4, 8'h00, 8'h00, 16'h0000);
        #1;
        check("otherDecode idle", 16'(otherDecode), 16'h0000);
    endtask : run_table

    task automatic run_targets();
        u_mod_fetch_model.issue(1'b1, 8'h12, 8'h12, 8'h34, 16'h0000);
        #1;
        check("longTarget", longTarget, 16'h1234);
        fetch(8'hE1, 8'h5C, 16'hF7FF);
        check("pageTarget", pageTarget, 16'hF75C);
        fetch(8'h01, 8'hFF, 16'h0800);
        check("pageTarget edge", pageTarget, 16'h08FF);
        fetch(8'h80, 8'h80, 16'h0010);
        check("relTarget back", relTarget, 16'hFF90);
        check("sfr low end", 16'({directIsSfr, directAddr}), 16'h0180);
        fetch(8'h80, 8'h7F, 16'h0010);
        check("relTarget fwd", relTarget, 16'h008F);
        check("data high end", 16'({directIsSfr, directAddr}), 16'h007F);
    endtask : run_targets

    initial begin
        rst_n = 1'b0;
        repeat (2) @(posedge ref_clk);
        #1;
        rst_n = 1'b1;
        run_bank();
        run_index();
        run_table();
        run_targets();
        close_out();
    end

    // whole run needs well under a thousand cycles
    initial begin
        #25000;
        err_total++;
        close_out();
    end
endmodule : testbench
`default_nettype wire
